/* shared/bols_hold_if.sv */
// Purpose: Link between forwarding logic and one release hold delay
// Assumes: Same clock on both sides
// Notes:   drive is the forwarded drive request, hold the blocking term
`timescale 1ns/1ps
`default_nettype none
interface bols_hold_if;
	logic drive;
	logic clear;
	logic hold;

	modport delay (
		input  drive,
		input  clear,
		output hold
	);
	modport user (
		output drive,
		output clear,
		input  hold
	);
endinterface
`default_nettype wire

/* shared/bols_pkg.sv */
// Purpose: Constants for the open-drain bus repeater
// Assumes: 20 MHz core clock
// Notes:   Pin levels idle high; drive enables are active low
package bols_pkg;

	// ********************
	// Timing
	// ********************
	localparam int CLK_FREQ_MHZ  = 20;
	// Release hold, covers the slow pull-up rise of a freed line
	localparam int HOLD_TIME_NS  = 400;
	// Least time, so round up
	localparam int HOLD_CYCLES   = (HOLD_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
	localparam int HOLD_W        = 4;
	localparam logic [HOLD_W-1:0] HOLD_LOAD = HOLD_W'(HOLD_CYCLES);
	localparam logic [HOLD_W-1:0] HOLD_RST  = 4'h0;

	// ********************
	// Channels and reset values
	// ********************
	localparam int NUM_CH        = 2;
	localparam int CH_CLOCK      = 0;
	localparam int CH_DATA       = 1;
	localparam int SYNC_W        = 5;
	localparam logic [SYNC_W-1:0] SYNC_RST  = 5'h1f;
	localparam logic [1:0]        OE_N_RST  = 2'h3;
	localparam logic              OUT_RST   = 1'b0;
	localparam logic              OSC_RST   = 1'b0;

endpackage

/* src/bols_release_hold_delay.sv */
// Purpose: Stretches the falling edge of a drive request
// Assumes: drive comes from a register on the same clock
// Notes:   hold is high while driving and for the hold time after
`timescale 1ns/1ps
`default_nettype none
module bols_release_hold_delay
	import bols_pkg::*;
(
	input  wire logic    i_clock,
	input  wire logic    i_rst_n,
	bols_hold_if.delay   hold_port
);

	logic [HOLD_W-1:0] count;
	logic [HOLD_W-1:0] next_count;

	// Reload while driving, count down once released
	always_comb begin
		next_count = count;
		if (hold_port.clear) begin
			next_count = HOLD_RST;
		end else if (hold_port.drive) begin
			next_count = HOLD_LOAD; // see RULE_08
		end else if (count != HOLD_RST) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			count <= HOLD_RST;
		end else begin
			count <= next_count;
		end
	end

	assign hold_port.hold = hold_port.drive | (count != HOLD_RST);

endmodule
`default_nettype wire

/* src/bols_repeater.sv */
// Purpose: Two-channel bidirectional repeater for an open-drain bus
// Assumes: External pull-ups on every pin; pins idle high
// Notes:   No direction input; direction follows who pulls low first
//
// Function
// RULE_01: Two independent channels, clock and data, one pin per side.
// RULE_02: Drive enable low leaves pin an input; high pulls the line low. Code's oe_n is active low: low pulls the line low, high leaves an input.
// RULE_03: Idle bus with both pins high keeps all gates low, pins inputs.
// RULE_04: A low pulled on one side drives the opposite pin low.
// RULE_05: Low forwards only while reverse hold feedback is low.
// RULE_06: Enable gates every forwarded request; disabled means no pin driven.
// RULE_07: Originating pin going high releases the opposite pin.
// RULE_08: A released drive holds a delayed block on reverse forwarding.
// RULE_09: Direction comes only from pin levels and internal gating.
// RULE_10: Enable low stops the internal oscillator.
// RULE_11: Latency and hold time short enough for 400 kbps traffic.
// RULE_12: Bus devices only pull low; resistors pull lines high.
// RULE_13: Pin levels pass two synchroniser flops before forwarding logic.
`timescale 1ns/1ps
`default_nettype none
module bols_repeater
	import bols_pkg::*;
(
	input  wire logic i_clock,
	input  wire logic i_rst_n,
	input  wire logic i_enable,
	input  wire logic i_side_one_clock_pin_in,
	output var  logic o_side_one_clock_pin_out,
	output var  logic o_side_one_clock_pin_oe_n,
	input  wire logic i_side_two_clock_pin_in,
	output var  logic o_side_two_clock_pin_out,
	output var  logic o_side_two_clock_pin_oe_n,
	input  wire logic i_side_one_data_pin_in,
	output var  logic o_side_one_data_pin_out,
	output var  logic o_side_one_data_pin_oe_n,
	input  wire logic i_side_two_data_pin_in,
	output var  logic o_side_two_data_pin_out,
	output var  logic o_side_two_data_pin_oe_n,
	output var  logic o_osc_run
);

	// ********************
	// Input synchronisers
	// ********************
	// Bit order: enable, data two, data one, clock two, clock one
	logic [SYNC_W-1:0] sync_a;
	logic [SYNC_W-1:0] sync_b;
	logic [SYNC_W-1:0] next_sync_a;
	logic [SYNC_W-1:0] next_sync_b;
	logic [NUM_CH-1:0] pin_one;
	logic [NUM_CH-1:0] pin_two;
	logic              enabled;

	always_comb begin
		next_sync_a = {i_enable,
			i_side_two_data_pin_in, i_side_one_data_pin_in,
			i_side_two_clock_pin_in, i_side_one_clock_pin_in};
		next_sync_b = sync_a; // see RULE_13
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sync_a <= SYNC_RST;
			sync_b <= SYNC_RST;
		end else begin
			sync_a <= next_sync_a;
			sync_b <= next_sync_b;
		end
	end

	assign pin_one = {sync_b[2], sync_b[0]};
	assign pin_two = {sync_b[3], sync_b[1]};
	assign enabled = sync_b[4];

	// ********************
	// Release hold delays
	// ********************
	logic [NUM_CH-1:0] oe_n_one;
	logic [NUM_CH-1:0] oe_n_two;
	logic [NUM_CH-1:0] hold_one;
	logic [NUM_CH-1:0] hold_two;

	// Index 0..1 stretch side two drives, 2..3 side one drives
	genvar g;
	generate
		for (g = 0; g < 2 * NUM_CH; g++) begin : g_hold
			bols_hold_if u_link ();
			// Counters idle while disabled, nothing to hold off
			assign u_link.clear = ~enabled; // see RULE_10
			if (g < NUM_CH) begin : g_two
				assign u_link.drive = ~oe_n_two[g];
				assign hold_two[g]  = u_link.hold;
			end else begin : g_one
				assign u_link.drive = ~oe_n_one[g-NUM_CH];
				assign hold_one[g-NUM_CH] = u_link.hold;
			end
			bols_release_hold_delay u_delay (
				.i_clock   (i_clock),
				.i_rst_n   (i_rst_n),
				.hold_port (u_link.delay)
			);
		end
	endgenerate

	// ********************
	// Crossing gates
	// ********************
	logic [NUM_CH-1:0] reverse_block_gate_one;
	logic [NUM_CH-1:0] reverse_block_gate_two;
	logic [NUM_CH-1:0] crossing_nor_gate_one;
	logic [NUM_CH-1:0] crossing_nor_gate_two;
	logic [NUM_CH-1:0] crossing_pass_gate_one;
	logic [NUM_CH-1:0] crossing_pass_gate_two;
	logic [NUM_CH-1:0] next_oe_n_one;
	logic [NUM_CH-1:0] next_oe_n_two;
	logic              out_level;
	logic              next_out_level;
	logic              osc_run;
	logic              next_osc_run;

	always_comb begin
		for (int c = 0; c < NUM_CH; c++) begin
			// Our own drive on a pin must not echo back across
			reverse_block_gate_two[c] = hold_one[c]; // see RULE_05
			reverse_block_gate_one[c] = hold_two[c]; // see RULE_05
			crossing_nor_gate_two[c] =
				~(pin_one[c] | reverse_block_gate_two[c]); // see RULE_04
			crossing_nor_gate_one[c] =
				~(pin_two[c] | reverse_block_gate_one[c]); // see RULE_04
			crossing_pass_gate_two[c] =
				crossing_nor_gate_two[c] & enabled; // see RULE_06
			// Both sides low at once: side one wins, never both driven
			crossing_pass_gate_one[c] = crossing_nor_gate_one[c] & enabled
				& ~crossing_pass_gate_two[c]; // see RULE_09
			next_oe_n_two[c] = ~crossing_pass_gate_two[c]; // see RULE_07
			next_oe_n_one[c] = ~crossing_pass_gate_one[c]; // see RULE_07
		end
		// Open drain: the data bit is always low
		next_out_level = OUT_RST; // see RULE_02
		next_osc_run   = enabled; // see RULE_10
	end

	always_ff @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			oe_n_one  <= OE_N_RST; // see RULE_03
			oe_n_two  <= OE_N_RST;
			out_level <= OUT_RST;
			osc_run   <= OSC_RST;
		end else begin
			oe_n_one  <= next_oe_n_one;
			oe_n_two  <= next_oe_n_two;
			out_level <= next_out_level;
			osc_run   <= next_osc_run;
		end
	end

	// ********************
	// Pin outputs
	// ********************
	// Two channels side by side, clock then data
	assign o_side_one_clock_pin_oe_n = oe_n_one[CH_CLOCK]; // see RULE_01
	assign o_side_two_clock_pin_oe_n = oe_n_two[CH_CLOCK];
	assign o_side_one_data_pin_oe_n  = oe_n_one[CH_DATA];
	assign o_side_two_data_pin_oe_n  = oe_n_two[CH_DATA];
	assign o_side_one_clock_pin_out  = out_level;
	assign o_side_two_clock_pin_out  = out_level;
	assign o_side_one_data_pin_out   = out_level;
	assign o_side_two_data_pin_out   = out_level;
	assign o_osc_run                 = osc_run;

	// ********************
	// Assertions
	// ********************
	a_disabled_no_drive: assert property ( // see RULE_06
		@(posedge i_clock) disable iff (!i_rst_n)
		!enabled |=> (oe_n_one == OE_N_RST) && (oe_n_two == OE_N_RST))
		else $error("Pin driven while disabled");

	a_fwd_one_two: assert property ( // see RULE_04
		@(posedge i_clock) disable iff (!i_rst_n)
		enabled && !pin_one[CH_CLOCK] && !hold_one[CH_CLOCK]
		|=> !oe_n_two[CH_CLOCK])
		else $error("Low on side one not forwarded");

	a_fwd_two_one: assert property ( // see RULE_04
		@(posedge i_clock) disable iff (!i_rst_n)
		enabled && !pin_two[CH_DATA] && !hold_two[CH_DATA]
		&& pin_one[CH_DATA] |=> !oe_n_one[CH_DATA])
		else $error("Low on side two not forwarded");

	a_reverse_blocked: assert property ( // see RULE_05
		@(posedge i_clock) disable iff (!i_rst_n)
		hold_two[CH_DATA] |=> oe_n_one[CH_DATA])
		else $error("Low echoed back through hold");

	a_release_follows: assert property ( // see RULE_07
		@(posedge i_clock) disable iff (!i_rst_n)
		pin_one[CH_CLOCK] ##1 pin_one[CH_CLOCK] |-> oe_n_two[CH_CLOCK])
		else $error("Opposite pin not released");

	a_hold_stretch: assert property ( // see RULE_08
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(oe_n_two[CH_CLOCK]) && enabled
		|-> (hold_two[CH_CLOCK] || !enabled)[*8])
		else $error("Release hold too short");

	a_hold_ends: assert property ( // see RULE_08
		@(posedge i_clock) disable iff (!i_rst_n)
		$rose(oe_n_one[CH_DATA]) ##1 (oe_n_one[CH_DATA])[*8]
		|-> !hold_one[CH_DATA])
		else $error("Release hold too long");

	a_one_way_only: assert property ( // see RULE_09
		@(posedge i_clock) disable iff (!i_rst_n)
		(oe_n_one | oe_n_two) == OE_N_RST)
		else $error("Both sides of a channel driven");

	a_idle_quiet: assert property ( // see RULE_03
		@(posedge i_clock) disable iff (!i_rst_n)
		(pin_one == OE_N_RST) && (pin_two == OE_N_RST)
		&& !hold_one[CH_CLOCK] && !hold_two[CH_CLOCK]
		|=> oe_n_one[CH_CLOCK] && oe_n_two[CH_CLOCK])
		else $error("Pin driven on idle bus");

	a_osc_follows: assert property ( // see RULE_10
		@(posedge i_clock) disable iff (!i_rst_n)
		$fell(sync_b[4]) |=> !o_osc_run)
		else $error("Oscillator runs while disabled");

	a_sync_latency: assert property ( // see RULE_13
		@(posedge i_clock) disable iff (!i_rst_n)
		$fell(oe_n_two[CH_DATA]) |-> !$past(i_side_one_data_pin_in, 3))
		else $error("Forward without synchronised low");

	a_fwd_latency: assert property ( // see RULE_11
		@(posedge i_clock) disable iff (!i_rst_n)
		!i_side_one_clock_pin_in && !oe_n_two[CH_CLOCK] ##1
		i_side_one_clock_pin_in |-> ##[1:4] oe_n_two[CH_CLOCK])
		else $error("Release latency too long");

	a_out_low: assert property ( // see RULE_02
		@(posedge i_clock) disable iff (!i_rst_n)
		!o_side_two_clock_pin_oe_n |-> !o_side_two_clock_pin_out)
		else $error("Driven pin not low");

endmodule
`default_nettype wire

/* test/bols_bus_model.sv */
// Purpose: Open-drain devices and pull-ups on both sides
// Assumes: Lines are clock one, clock two, data one, data two
// Notes:   i_slow stretches every release by three cycles
`timescale 1ns/1ps
`default_nettype none
module bols_bus_model (
	input  wire logic       i_clock,
	input  wire logic       i_slow,
	input  wire logic [3:0] i_pull,
	input  wire logic [3:0] i_oe_n,
	output logic      [3:0] o_level
);
	logic [3:0] low;
	logic [3:0] s1, s2, s3;
	// Devices only sink current, resistors raise the line
	assign low = i_pull | ~i_oe_n;
	always_ff @(posedge i_clock) begin
		s1 <= low;
		s2 <= s1;
		s3 <= s2;
	end
	// Slow pull-up rise seen as a late release
	assign o_level = ~(low | ({4{i_slow}} & (s1 | s2 | s3)));
endmodule
`default_nettype wire

/* test/bols_repeater_tb.sv */
// Purpose: Self-checking bench for the open-drain repeater
// Assumes: 50 ns clock, pins idle high through every reset
// Notes:   Reference model is checked on every cycle except the four after each reset
`timescale 1ns/1ps
`default_nettype none
module bols_repeater_tb;
	import bols_pkg::*;
	logic       i_clock  = 1'b0;
	logic       i_rst_n  = 1'b0;
	logic       i_enable = 1'b1;
	logic       slow     = 1'b0;
	logic [3:0] pull     = 4'h0;
	wire logic [3:0] lvl;
	wire logic [3:0] oe_n;
	wire logic [3:0] pin_out;
	logic       o_osc_run;
	logic [7:0] rnd = 8'h24;
	logic [1:0] d;
	logic [8:0] exp_v, got_v;
	int fails = 0;
	int check_count = 0;
	int sa[5], sb[5], drv[4], cnt[4];
	int osc, settle;

	always #25 i_clock = ~i_clock;

	bols_repeater uut (
		.i_clock                   (i_clock),
		.i_rst_n                   (i_rst_n),
		.i_enable                  (i_enable),
		.i_side_one_clock_pin_in   (lvl[0]),
		.o_side_one_clock_pin_out  (pin_out[0]),
		.o_side_one_clock_pin_oe_n (oe_n[0]),
		.i_side_two_clock_pin_in   (lvl[1]),
		.o_side_two_clock_pin_out  (pin_out[1]),
		.o_side_two_clock_pin_oe_n (oe_n[1]),
		.i_side_one_data_pin_in    (lvl[2]),
		.o_side_one_data_pin_out   (pin_out[2]),
		.o_side_one_data_pin_oe_n  (oe_n[2]),
		.i_side_two_data_pin_in    (lvl[3]),
		.o_side_two_data_pin_out   (pin_out[3]),
		.o_side_two_data_pin_oe_n  (oe_n[3]),
		.o_osc_run                 (o_osc_run)
	);
	bols_bus_model bus (
		.i_clock (i_clock),
		.i_slow  (slow),
		.i_pull  (pull),
		.i_oe_n  (oe_n),
		.o_level (lvl)
	);

	// ****************
	// Reference model
	// ****************
	task automatic upd(input int x, input int n);
		if (!sb[4])
			cnt[x] = 0;
		else if (drv[x] && !n)
			cnt[x] = HOLD_CYCLES;
		else if (cnt[x] > 0)
			cnt[x]--;
		drv[x] = n;
	endtask
	task automatic step(input int a);
		int b, ha, hb, na, nb;
		b = a + 1;
		ha = drv[a] | (cnt[a] > 0);
		hb = drv[b] | (cnt[b] > 0);
		nb = sb[4] & !sb[a] & !ha;
		na = sb[4] & !sb[b] & !hb & !nb;
		upd(a, na);
		upd(b, nb);
	endtask
	always @(posedge i_clock or negedge i_rst_n) begin
		if (!i_rst_n) begin
			drv = '{0, 0, 0, 0};
			cnt = '{0, 0, 0, 0};
			sa = '{1, 1, 1, 1, 1};
			sb = '{1, 1, 1, 1, 1};
			osc = 0;
			settle = 4;
		end else begin
			osc = sb[4];
			for (int c = 0; c < 4; c += 2) step(c);
			for (int k = 0; k < 5; k++) begin
				sb[k] = sa[k];
				sa[k] = (k < 4) ? lvl[k] : i_enable;
			end
			if (settle > 0)
				settle--;
		end
	end

	task automatic chk(input logic [8:0] got, input logic [8:0] want);
		check_count++;
		if (got !== want) begin
			fails++;
			$display("MISMATCH at %0t: got %h want %h", $time, got, want);
		end
	endtask
	always @(negedge i_clock) begin
		exp_v = {1'b0, 4'h0, 4'hf};
		got_v = {o_osc_run, pin_out, oe_n};
		if (i_rst_n) begin
			exp_v[8] = osc[0];
			for (int l = 0; l < 4; l++) exp_v[l] = !drv[l];
		end
		if (!i_rst_n || settle == 0)
			chk(got_v, exp_v);
	end

	task automatic stop_test;
		$display("Comparisons %0d, mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	function automatic logic [7:0] lfsr(input logic [7:0] v);
		return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
	endfunction

	// ****************
	// Scenarios
	// ****************
	initial begin
		cyc(10);
		i_rst_n <= 1'b1;
		cyc(10);
		// Every line, prompt and then with slow rise for echo
		for (int s = 0; s < 2; s++) begin
			for (int l = 0; l < 4; l++) begin
				slow <= s[0];
				pull[l] <= 1'b1;
				cyc(6);
				pull[l] <= 1'b0;
				cyc(20);
			end
		end
		slow <= 1'b0;
		// Both sides at once, side one wins
		pull <= 4'hf;
		cyc(8);
		pull <= 4'h0;
		cyc(20);
		// Enable dropped mid-drive, then restored
		pull <= 4'h5;
		cyc(6);
		i_enable <= 1'b0;
		cyc(8);
		i_enable <= 1'b1;
		cyc(8);
		pull <= 4'h0;
		cyc(20);
		// Reset in mid-drive
		pull <= 4'h2;
		cyc(6);
		pull <= 4'h0;
		i_rst_n <= 1'b0;
		cyc(3);
		i_rst_n <= 1'b1;
		cyc(10);
		// Random bursts, one side per channel, gap lets holds expire
		repeat (40) begin
			rnd = lfsr(rnd);
			d = rnd[1:0];
			repeat (12) begin
				rnd = lfsr(rnd);
				pull <= {rnd[1] & d[1], rnd[1] & ~d[1],
					rnd[0] & d[0], rnd[0] & ~d[0]};
				cyc(1 + int'(rnd[4:2]));
			end
			pull <= 4'h0;
			cyc(20);
		end
		stop_test();
	end

	initial begin
		#(20000 * 50);
		fails++;
		stop_test();
	end
endmodule
`default_nettype wire
